// ==== astrc_pkg.sv ====
// astrc_pkg: register map, control layout and encodings of the serial unit.
// assumes an AHB-Lite slave with one aligned 32-bit word per register.
package astrc_pkg;

    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_BAUD   = 8'h04;
    localparam logic [7:0]  ADDR_TXDATA = 8'h08;
    localparam logic [7:0]  ADDR_RXDATA = 8'h0C;
    localparam logic [7:0]  ADDR_STATUS = 8'h10;

    localparam int          CTRL_W      = 11;
    localparam logic [10:0] CTRL_RST    = 11'h000;
    localparam logic [15:0] BAUD_RST    = 16'h0040;
    localparam logic [8:0]  DATA_RST    = 9'h1FF;
    localparam logic [8:0]  BYTE_MASK   = 9'h0FF;

    localparam int ST_TSF = 7;
    localparam int ST_PE  = 2;
    localparam int ST_FE  = 1;
    localparam int ST_OVE = 0;

    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD  = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;

    localparam logic [3:0] LEN_7 = 4'h7;
    localparam logic [3:0] LEN_8 = 4'h8;
    localparam logic [3:0] LEN_9 = 4'h9;

    // first field is the top bit: power sits at bit 0
    typedef struct packed {
        logic       rx_inv;
        logic       tx_inv;
        logic       stop2;
        logic [1:0] parity;
        logic       nine;
        logic       len8;
        logic       msb_first;
        logic       rxe;
        logic       txe;
        logic       pwr;
    } astrc_ctrl_t;

    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
    } astrc_tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
    } astrc_rx_state_t;

endpackage : astrc_pkg

// ==== astrc_sync3.sv ====
// astrc_sync3: three-stage input synchroniser with agreement filter.
// assumes the input is asynchronous to clk; output follows once stages agree.
`timescale 1ns/1ps
`default_nettype none
module astrc_sync3 #(
    parameter logic IDLE_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic din,
    output var  logic dout
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= IDLE_VAL;
            s2_r <= IDLE_VAL;
            s3_r <= IDLE_VAL;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dout <= IDLE_VAL;
        end else if (s2_r == s3_r) begin
            dout <= s3_r;
        end
    end
endmodule : astrc_sync3
`default_nettype wire

// ==== astrc_core.sv ====
// astrc_core: asynchronous serial transmitter/receiver with AHB-Lite regs.
// assumes a single 10 MHz clock, synchronous reset, zero-wait-state bus.
//
// Notes on behaviour
// - 7-bit chars: LSB-first uses bits 6..0, MSB-first uses bits 7..1.
// - transmit data register resets to all ones, 0xFF or 0x1FF.
// - data written while transmit disabled never starts a frame.
// - with power and transmit enable, a data write starts a framed character.
// - on load into shifter, pulse transmit interrupt, then shift out.
// - receive interrupt wins over transmit interrupt when both pending.
// - receive interrupt on data move or error, never while disabled.
// - frame: start, 7/8/9 bits, parity option, 1 or 2 stops.
// - separate bits invert the output line and the input line.
// - start accepted only if line still low half a bit after edge.
// - at stop bit, move shift data to receive register and interrupt.
// - overrun discards character; parity/framing errors still store it.
// - receiver checks only the first stop bit.
// - each error sets its status flag and raises receive interrupt.
// - no spurious receive interrupt at shutdown; rx_done is gated by receive enable.
// - overrun flag set when reception ends with previous data unread.
// - transfer status is one while shifter holds data, else zero.
`timescale 1ns/1ps
`default_nettype none
module astrc_core #(
    parameter int DIV_W = 16
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    input  wire logic        serial_in_line,
    output var  logic        serial_out_line,
    output var  logic        transmit_enable_irq,
    output var  logic        receive_complete_irq
);
    if (DIV_W < 2 || DIV_W > 16) begin : g_div_check
        $error("DIV_W must be 2..16");
    end

    astrc_pkg::astrc_ctrl_t     ctrl_r;
    logic [DIV_W-1:0]           baud_r;
    logic [8:0]                 tx_hold_r;
    logic                       tx_pend_r;
    logic [8:0]                 tx_sh_r;
    logic [3:0]                 tx_idx_r;
    logic                       tx_par_r;
    logic [DIV_W-1:0]           tx_cnt_r;
    logic                       tsf_r;
    logic                       tx_irq_q_r;
    astrc_pkg::astrc_tx_state_t tx_state_r;
    logic [8:0]                 rx_data_r;
    logic                       rx_full_r;
    logic [8:0]                 rx_sh_r;
    logic [3:0]                 rx_idx_r;
    logic                       rx_par_r;
    logic                       rx_perr_r;
    logic [DIV_W-1:0]           rx_cnt_r;
    logic                       rx_prev_r;
    astrc_pkg::astrc_rx_state_t rx_state_r;
    logic                       pe_r;
    logic                       fe_r;
    logic                       ove_r;
    logic                       wr_r;
    logic [7:0]                 addr_r;
    logic                       rx_sync;

    logic             ap;
    logic             tx_en;
    logic             rx_en;
    logic             tx_wr;
    logic             tx_load;
    logic             tx_tick;
    logic             rx_tick;
    logic             rx_line;
    logic             rx_done;
    logic             rx_rd;
    logic             tx_bit;
    logic [3:0]       nbits;
    logic [DIV_W-1:0] period_m1;

    function automatic logic [3:0] char_len(astrc_pkg::astrc_ctrl_t c);
        if (c.nine) begin
            return astrc_pkg::LEN_9;
        end else if (c.len8) begin
            return astrc_pkg::LEN_8;
        end
        return astrc_pkg::LEN_7;
    endfunction : char_len

    // bit position of the i-th bit on the wire
    function automatic logic [3:0] src_idx(astrc_pkg::astrc_ctrl_t c,
                                           logic [3:0] i);
        logic [3:0] top;
        top = c.nine ? astrc_pkg::LEN_8 : astrc_pkg::LEN_7;
        return c.msb_first ? top - i : i;
    endfunction : src_idx

    function automatic logic [8:0] len_mask(logic [8:0] v, logic nine);
        return nine ? v : (v & astrc_pkg::BYTE_MASK);
    endfunction : len_mask

    localparam int ST_TSF = astrc_pkg::ST_TSF;
    localparam int ST_PE  = astrc_pkg::ST_PE;
    localparam int ST_FE  = astrc_pkg::ST_FE;
    localparam int ST_OVE = astrc_pkg::ST_OVE;

    assign tx_en     = ctrl_r.pwr & ctrl_r.txe;
    assign rx_en     = ctrl_r.pwr & ctrl_r.rxe;
    assign nbits     = char_len(ctrl_r);
    assign period_m1 = (baud_r == '0) ? DIV_W'(1) : baud_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ---- bus slave ----
    assign ap    = hsel & htrans[1] & hready;
    assign tx_wr = wr_r & (addr_r == astrc_pkg::ADDR_TXDATA);
    assign rx_rd = ap & ~hwrite & (haddr[7:0] == astrc_pkg::ADDR_RXDATA);

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_r   <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            wr_r   <= ap & hwrite;
            addr_r <= haddr[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (ap & ~hwrite) begin
            case (haddr[7:0])
                astrc_pkg::ADDR_CTRL:   hrdata <= 32'(ctrl_r);
                astrc_pkg::ADDR_BAUD:   hrdata <= 32'(baud_r);
                astrc_pkg::ADDR_TXDATA:
                    hrdata <= 32'(len_mask(tx_hold_r, ctrl_r.nine));
                astrc_pkg::ADDR_RXDATA:
                    hrdata <= 32'(len_mask(rx_data_r, ctrl_r.nine));
                astrc_pkg::ADDR_STATUS: begin
                    hrdata         <= 32'h00000000;
                    hrdata[ST_TSF] <= tsf_r;
                    hrdata[ST_PE]  <= pe_r;
                    hrdata[ST_FE]  <= fe_r;
                    hrdata[ST_OVE] <= ove_r;
                end
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= astrc_pkg::CTRL_RST;
            baud_r <= DIV_W'(astrc_pkg::BAUD_RST);
        end else if (wr_r && addr_r == astrc_pkg::ADDR_CTRL) begin
            ctrl_r <= hwdata[astrc_pkg::CTRL_W-1:0];
        end else if (wr_r && addr_r == astrc_pkg::ADDR_BAUD) begin
            baud_r <= hwdata[DIV_W-1:0];
        end
    end

    // ---- transmit holding register ----
    assign tx_load = tx_en & tx_pend_r & (tx_state_r == astrc_pkg::TX_IDLE);

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_hold_r <= astrc_pkg::DATA_RST;
        end else if (tx_wr) begin
            tx_hold_r <= hwdata[8:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !tx_en) begin
            tx_pend_r <= 1'b0;
        end else if (tx_wr) begin
            tx_pend_r <= 1'b1;
        end else if (tx_load) begin
            tx_pend_r <= 1'b0;
        end
    end

    // ---- transmitter ----
    assign tx_tick = (tx_cnt_r == '0);

    always_comb begin
        case (tx_state_r)
            astrc_pkg::TX_START: tx_bit = 1'b0;
            astrc_pkg::TX_DATA:  tx_bit = tx_sh_r[src_idx(ctrl_r, tx_idx_r)];
            astrc_pkg::TX_PAR:
                tx_bit = (ctrl_r.parity == astrc_pkg::PAR_EVEN) ? tx_par_r
                       : (ctrl_r.parity == astrc_pkg::PAR_ODD) ? ~tx_par_r
                       : 1'b0;
            default:             tx_bit = 1'b1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            serial_out_line <= 1'b1;
        end else begin
            serial_out_line <= tx_bit ^ ctrl_r.tx_inv;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !tx_en) begin
            tx_state_r <= astrc_pkg::TX_IDLE;
            tx_sh_r    <= astrc_pkg::DATA_RST;
            tx_idx_r   <= 4'h0;
            tx_par_r   <= 1'b0;
            tx_cnt_r   <= '0;
            tsf_r      <= 1'b0;
        end else begin
            tx_cnt_r <= tx_tick ? period_m1 : tx_cnt_r - DIV_W'(1);
            case (tx_state_r)
                astrc_pkg::TX_IDLE: begin
                    if (tx_load) begin
                        tx_sh_r    <= tx_hold_r;
                        tx_idx_r   <= 4'h0;
                        tx_par_r   <= 1'b0;
                        tx_cnt_r   <= period_m1;
                        tsf_r      <= 1'b1;
                        tx_state_r <= astrc_pkg::TX_START;
                    end
                end
                astrc_pkg::TX_START: begin
                    if (tx_tick) tx_state_r <= astrc_pkg::TX_DATA;
                end
                astrc_pkg::TX_DATA: begin
                    if (tx_tick) begin
                        tx_par_r <= tx_par_r ^ tx_bit;
                        tx_idx_r <= tx_idx_r + 4'h1;
                        if (tx_idx_r == nbits - 4'h1) begin
                            tx_idx_r   <= 4'h0;
                            tx_state_r <= (ctrl_r.parity == astrc_pkg::PAR_NONE)
                                        ? astrc_pkg::TX_STOP
                                        : astrc_pkg::TX_PAR;
                        end
                    end
                end
                astrc_pkg::TX_PAR: begin
                    if (tx_tick) tx_state_r <= astrc_pkg::TX_STOP;
                end
                astrc_pkg::TX_STOP: begin
                    if (tx_tick) begin
                        if (ctrl_r.stop2 && tx_idx_r == 4'h0) begin
                            tx_idx_r <= 4'h1;
                        end else begin
                            tx_state_r <= astrc_pkg::TX_IDLE;
                            tsf_r      <= tx_pend_r;
                        end
                    end
                end
                default: tx_state_r <= astrc_pkg::TX_IDLE;
            endcase
        end
    end

    // ---- interrupt pulses ----
    always_ff @(posedge clk) begin
        if (rst) begin
            receive_complete_irq <= 1'b0;
            transmit_enable_irq  <= 1'b0;
            tx_irq_q_r           <= 1'b0;
        end else begin
            receive_complete_irq <= rx_done;
            // a transmit event waits while a receive pulse goes out
            if (rx_done) begin
                transmit_enable_irq <= 1'b0;
                tx_irq_q_r          <= tx_irq_q_r | tx_load;
            end else begin
                transmit_enable_irq <= tx_irq_q_r | tx_load;
                tx_irq_q_r          <= 1'b0;
            end
        end
    end

    // ---- receiver ----
    astrc_sync3 #(.IDLE_VAL(1'b1)) u_rx_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (serial_in_line),
        .dout (rx_sync)
    );

    assign rx_line = rx_sync ^ ctrl_r.rx_inv;
    assign rx_tick = (rx_cnt_r == '0);
    assign rx_done = rx_en & rx_tick
                   & (rx_state_r == astrc_pkg::RX_STOP);

    always_ff @(posedge clk) begin
        if (rst || !rx_en) begin
            rx_state_r <= astrc_pkg::RX_IDLE;
            rx_sh_r    <= 9'h000;
            rx_idx_r   <= 4'h0;
            rx_par_r   <= 1'b0;
            rx_perr_r  <= 1'b0;
            rx_cnt_r   <= '0;
            rx_prev_r  <= 1'b1;
        end else begin
            rx_prev_r <= rx_line;
            rx_cnt_r  <= rx_tick ? period_m1 : rx_cnt_r - DIV_W'(1);
            case (rx_state_r)
                astrc_pkg::RX_IDLE: begin
                    if (rx_prev_r && !rx_line) begin
                        rx_cnt_r   <= period_m1 >> 1;
                        rx_sh_r    <= 9'h000;
                        rx_idx_r   <= 4'h0;
                        rx_par_r   <= 1'b0;
                        rx_perr_r  <= 1'b0;
                        rx_state_r <= astrc_pkg::RX_START;
                    end
                end
                astrc_pkg::RX_START: begin
                    if (rx_tick) begin
                        rx_state_r <= rx_line ? astrc_pkg::RX_IDLE
                                              : astrc_pkg::RX_DATA;
                    end
                end
                astrc_pkg::RX_DATA: begin
                    if (rx_tick) begin
                        rx_sh_r[src_idx(ctrl_r, rx_idx_r)] <= rx_line;
                        rx_par_r <= rx_par_r ^ rx_line;
                        rx_idx_r <= rx_idx_r + 4'h1;
                        if (rx_idx_r == nbits - 4'h1) begin
                            rx_state_r <= (ctrl_r.parity == astrc_pkg::PAR_NONE)
                                        ? astrc_pkg::RX_STOP
                                        : astrc_pkg::RX_PAR;
                        end
                    end
                end
                astrc_pkg::RX_PAR: begin
                    if (rx_tick) begin
                        rx_perr_r <=
                            ((ctrl_r.parity == astrc_pkg::PAR_EVEN) &
                             (rx_par_r ^ rx_line)) |
                            ((ctrl_r.parity == astrc_pkg::PAR_ODD) &
                             ~(rx_par_r ^ rx_line));
                        rx_state_r <= astrc_pkg::RX_STOP;
                    end
                end
                astrc_pkg::RX_STOP: begin
                    if (rx_tick) rx_state_r <= astrc_pkg::RX_IDLE;
                end
                default: rx_state_r <= astrc_pkg::RX_IDLE;
            endcase
        end
    end

    // ---- receive data and error flags ----
    always_ff @(posedge clk) begin
        if (rst || !ctrl_r.pwr) begin
            rx_data_r <= astrc_pkg::DATA_RST;
            rx_full_r <= 1'b0;
        end else if (rx_done && (!rx_full_r || rx_rd)) begin
            rx_data_r <= rx_sh_r;
            rx_full_r <= 1'b1;
        end else if (rx_rd) begin
            rx_full_r <= 1'b0;
        end
    end

    // a flag set by a completing frame wins over a zero written to it
    always_ff @(posedge clk) begin
        if (rst || !rx_en) begin
            pe_r  <= 1'b0;
            fe_r  <= 1'b0;
            ove_r <= 1'b0;
        end else begin
            if (wr_r && addr_r == astrc_pkg::ADDR_STATUS) begin
                pe_r  <= pe_r & hwdata[ST_PE];
                fe_r  <= fe_r & hwdata[ST_FE];
                ove_r <= ove_r & hwdata[ST_OVE];
            end
            if (rx_done) begin
                if (rx_perr_r) pe_r <= 1'b1;
                if (!rx_line) fe_r <= 1'b1;
                if (rx_full_r && !rx_rd) ove_r <= 1'b1;
            end
        end
    end

    // ---- checks ----
    property p_tx_no_start;
        @(posedge clk) disable iff (rst)
        (tx_wr && !tx_en) |=> !tx_pend_r;
    endproperty
    a_tx_no_start: assert property (p_tx_no_start)
        else $error("write while disabled armed transmitter");

    property p_tx_start;
        @(posedge clk) disable iff (rst)
        (tx_wr && tx_en && !tx_pend_r && tx_state_r == astrc_pkg::TX_IDLE)
        |-> ##2 (tx_state_r == astrc_pkg::TX_START && tsf_r);
    endproperty
    a_tx_start: assert property (p_tx_start)
        else $error("enabled write did not start a frame");

    property p_tx_irq;
        @(posedge clk) disable iff (rst)
        tx_load |-> ##[1:2] transmit_enable_irq;
    endproperty
    a_tx_irq: assert property (p_tx_irq)
        else $error("no transmit pulse after load");

    property p_irq_prio;
        @(posedge clk) disable iff (rst)
        !(transmit_enable_irq && receive_complete_irq);
    endproperty
    a_irq_prio: assert property (p_irq_prio)
        else $error("both interrupt pulses in one cycle");

    property p_rx_gate;
        @(posedge clk) disable iff (rst)
        receive_complete_irq |-> $past(rx_en);
    endproperty
    a_rx_gate: assert property (p_rx_gate)
        else $error("receive pulse while reception disabled");

    property p_start_reject;
        @(posedge clk) disable iff (rst || !rx_en)
        (rx_state_r == astrc_pkg::RX_START && rx_tick && rx_line)
        |=> rx_state_r == astrc_pkg::RX_IDLE;
    endproperty
    a_start_reject: assert property (p_start_reject)
        else $error("glitch accepted as start bit");

    property p_rx_move;
        @(posedge clk) disable iff (rst || !ctrl_r.pwr)
        (rx_done && !rx_full_r)
        |=> (rx_data_r == $past(rx_sh_r)) && receive_complete_irq;
    endproperty
    a_rx_move: assert property (p_rx_move)
        else $error("stop bit did not move data and interrupt");

    property p_overrun;
        @(posedge clk) disable iff (rst || !rx_en)
        (rx_done && rx_full_r && !rx_rd)
        |=> ove_r && $stable(rx_data_r) && receive_complete_irq;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun did not discard and flag");

    property p_tsf_clear;
        @(posedge clk) disable iff (rst)
        !tx_en |=> !tsf_r;
    endproperty
    a_tsf_clear: assert property (p_tsf_clear)
        else $error("transfer status set while transmit disabled");

    property p_tx_reset;
        @(posedge clk) rst |=> tx_hold_r == astrc_pkg::DATA_RST;
    endproperty
    a_tx_reset: assert property (p_tx_reset)
        else $error("transmit data not all ones after reset");

    c_frame_sent: cover property (@(posedge clk) disable iff (rst)
        tx_state_r == astrc_pkg::TX_STOP ##1 tx_state_r == astrc_pkg::TX_START);
    c_rx_done: cover property (@(posedge clk) disable iff (rst)
        rx_done && !rx_full_r);
    c_overrun: cover property (@(posedge clk) disable iff (rst)
        rx_done && rx_full_r);
endmodule : astrc_core
`default_nettype wire

// ==== astrc_peer.sv ====
// astrc_peer: remote serial node on the transmit and receive lines.
// assumes idle-high lines and a bit period of BIT clocks.
`timescale 1ns/1ps
`default_nettype none
module astrc_peer #(
    parameter int BIT = 4
) (
    input  wire logic clk,
    input  wire logic from_dut,
    output var  logic to_dut
);
    initial to_dut = 1'b1;

    // frame bits leave bit 0 first; bit 0 is the start bit
    task automatic send(input logic [15:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            to_dut <= b[i];
            repeat (BIT - 1) @(posedge clk);
        end
        @(posedge clk);
        to_dut <= 1'b1;
    endtask : send

    // waits for a start bit, then samples each bit at its middle
    task automatic grab(output logic [15:0] b, input int n);
        int k;
        b = 16'h0000;
        for (k = 0; k < 400 && from_dut !== 1'b0; k++) @(negedge clk);
        repeat (BIT / 2) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            b[i] = from_dut;
            if (i < n - 1) repeat (BIT) @(negedge clk);
        end
    endtask : grab

    // low pulse of two clocks, half a bit when BIT is 4
    task automatic glitch;
        @(posedge clk);
        to_dut <= 1'b0;
        repeat (2) @(posedge clk);
        to_dut <= 1'b1;
    endtask : glitch
endmodule : astrc_peer
`default_nettype wire

// ==== tb_top.sv ====
// tb_top: self-checking bench for the serial unit and its registers.
// assumes a zero-wait bus slave and astrc_peer on the serial lines.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    error_cnt++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
    localparam int P = 4;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        rx_line;
    logic        tx_line;
    logic        tx_irq;
    logic        rx_irq;
    logic [31:0] q;
    logic [15:0] got;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          cyc = 0;

    always #50 clk = ~clk;

    astrc_core i_astrc_core (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .serial_in_line(rx_line),
        .serial_out_line(tx_line), .transmit_enable_irq(tx_irq),
        .receive_complete_irq(rx_irq)
    );
    astrc_peer #(.BIT(P)) i_astrc_peer (
        .clk(clk), .from_dut(tx_line), .to_dut(rx_line)
    );

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        bus(1'b0, a, 32'h0, r);
    endtask : rd

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic t_gate; // data written while disabled stays put
        int hi;
        hi = 0;
        wr(astrc_pkg::ADDR_TXDATA, 32'h12);
        wr(astrc_pkg::ADDR_CTRL, 32'h3);
        repeat (60) begin
            @(negedge clk);
            hi += int'(tx_line === 1'b1 && tx_irq === 1'b0);
        end
        `CHK("no_start", 60, hi)
        $display("t_gate done");
    endtask : t_gate

    task automatic tx_one(input logic [31:0] c, input logic [31:0] d,
                          input logic [15:0] e, input int n);
        int k;
        wr(astrc_pkg::ADDR_CTRL, 32'h0);
        wr(astrc_pkg::ADDR_CTRL, c);
        fork
            i_astrc_peer.grab(got, n);
            begin
                wr(astrc_pkg::ADDR_TXDATA, d);
                for (k = 0; k < 20 && tx_irq !== 1'b1; k++) @(negedge clk);
                `CHK("tx_irq", 1'b1, tx_irq)
                rd(astrc_pkg::ADDR_STATUS, q);
                `CHK("tsf_busy", 1'b1, q[astrc_pkg::ST_TSF])
            end
        join
        `CHK("tx_frame", e, got)
        repeat (2 * P) @(negedge clk);
        rd(astrc_pkg::ADDR_STATUS, q);
        `CHK("tsf_idle", 1'b0, q[astrc_pkg::ST_TSF])
        $display("tx_one done");
    endtask : tx_one

    task automatic t_b2b; // next character written while one shifts
        int k;
        logic [15:0] g1;
        wr(astrc_pkg::ADDR_CTRL, 32'h0);
        wr(astrc_pkg::ADDR_CTRL, 32'hD7);
        fork
            begin
                i_astrc_peer.grab(g1, 11);
                i_astrc_peer.grab(got, 11);
            end
            begin
                wr(astrc_pkg::ADDR_TXDATA, 32'h81);
                for (k = 0; k < 20 && tx_irq !== 1'b1; k++) @(negedge clk);
                wr(astrc_pkg::ADDR_TXDATA, 32'h7E);
            end
        join
        `CHK("b2b_first", {5'h0, 1'b1, ^8'h81, 8'h81, 1'b0}, g1)
        `CHK("b2b_second", {5'h0, 1'b1, ^8'h7E, 8'h7E, 1'b0}, got)
        repeat (2 * P) @(negedge clk);
        $display("t_b2b done");
    endtask : t_b2b

    task automatic t_glitch; // short low pulse is not a start bit
        int k;
        i_astrc_peer.glitch();
        for (k = 0; k < 80 && rx_irq !== 1'b1; k++) @(negedge clk);
        `CHK("glitch_irq", 80, k)
        rd(astrc_pkg::ADDR_STATUS, q);
        `CHK("glitch_status", 32'h0, q)
        $display("t_glitch done");
    endtask : t_glitch

    task automatic rx_one(input logic [15:0] b, input logic [31:0] es,
                          input logic rd_data, input logic [31:0] ed);
        int k;
        fork
            i_astrc_peer.send(b, 11);
            for (k = 0; k < 200 && rx_irq !== 1'b1; k++) @(negedge clk);
        join
        `CHK("rx_irq", 1'b1, k < 200)
        rd(astrc_pkg::ADDR_STATUS, q);
        `CHK("rx_status", es, q)
        if (rd_data)
            rd(astrc_pkg::ADDR_RXDATA, q);
        if (rd_data)
            `CHK("rx_data", ed, q)
        wr(astrc_pkg::ADDR_STATUS, 32'h0);
        $display("rx_one done");
    endtask : rx_one

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(astrc_pkg::ADDR_TXDATA, q);
        `CHK("tx_reset", 32'hFF, q)
        rd(8'h20, q);
        `CHK("unmapped", 32'h0, q)
        `CHK("hresp", 1'b0, hresp)
        wr(astrc_pkg::ADDR_BAUD, P - 1);
        t_gate();
        // 8 bits lsb first, even parity; then 7 bits msb first, zero parity
        tx_one(32'hD7, 32'h5A, {5'h0, 1'b1, ^8'h5A, 8'h5A, 1'b0}, 11);
        tx_one(32'h4B, 32'hB5, {6'h0, 1'b1, 1'b0, 7'h2D, 1'b0}, 10);
        t_b2b();
        wr(astrc_pkg::ADDR_CTRL, 32'h0);
        wr(astrc_pkg::ADDR_CTRL, 32'hD7);
        t_glitch();
        rx_one({5'h0, 1'b1, ^8'h3C, 8'h3C, 1'b0}, 32'h0, 1'b0, 32'h0);
        rx_one({5'h0, 1'b1, ^8'hC3, 8'hC3, 1'b0}, 32'h1, 1'b1, 32'h3C);
        rx_one({5'h0, 1'b1, ~^8'h55, 8'h55, 1'b0}, 32'h4, 1'b1, 32'h55);
        rx_one({5'h0, 1'b0, ^8'hA5, 8'hA5, 1'b0}, 32'h2, 1'b1, 32'hA5);
        wr(astrc_pkg::ADDR_CTRL, 32'h0);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
